// ==== field_model.sv ====
// Purpose: sensors, curtain and operator controls at the far side
// Assumes: levels change only at the falling clock edge
// Notes:   opening free and everything idle at time zero
`timescale 1ns/1ps
`default_nettype none
module field_model (
  input  wire logic clk,
  output logic      cf,
  output logic      s1,
  output logic      s2,
  output logic      en,
  output logic      cmd,
  output logic      btn
);
  initial {cf, s1, s2, en, cmd, btn} = 6'h20;
  // curtain and both beams
  task scene(input logic c, input logic a, input logic b);
    @(negedge clk);
    cf = c;
    s1 = a;
    s2 = b;
  endtask
  // enable is dropped before each new arming edge
  task put_en(input logic v);
    @(negedge clk);
    en = v;
  endtask
  // operator command level, held until the next call
  task put_cmd(input logic v);
    @(negedge clk);
    cmd = v;
  endtask
  task put_btn(input logic v);
    @(negedge clk);
    btn = v;
  endtask
endmodule
`default_nettype wire

// ==== ms_timer.v ====
// Purpose: millisecond counter with a programmable limit and expiry flag
// Assumes: tick is a one-cycle enable pulse, one per millisecond
// Notes:   a limit of zero means unlimited; the counter saturates
`timescale 1ns/1ps
`default_nettype none
`include "muting_regs.vh"

module ms_timer #(
  parameter W = 24
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         tick,       // millisecond enable pulse
  input  wire         run,        // count while high, clear while low
  input  wire [W-1:0] limit,      // expiry point, zero is unlimited
  output reg          expired     // level, high once limit reached
);

  reg [W-1:0] count_reg;          // elapsed milliseconds

  ////////////////////////////////////////////////////////////////////////
  // count up while running; clearing on run low restarts every window
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {W{1'b0}};
      expired   <= 1'b0;
    end else if (!run) begin
      count_reg <= {W{1'b0}};
      expired   <= 1'b0;
    end else begin
      if (tick && (count_reg != {W{1'b1}})) begin
        count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
      end
      // unlimited limit never expires
      expired <= (limit != {W{1'b0}}) && (count_reg >= limit);
    end
  end

endmodule

`default_nettype wire

// ==== muting_checker.sv ====
// Purpose: concurrent checks on the muting block ports
// Assumes: single clock domain, async active-low reset
// Notes:   latencies follow the one-edge answer of the design
`timescale 1ns/1ps
`default_nettype none
`include "muting_regs.vh"
module muting_checker (
  input wire logic              CLOCK,
  input wire logic              RST_N,
  input wire logic              CURTAIN_FREE,
  input wire logic              FIRST_MUTING_SENSOR,
  input wire logic              SECOND_MUTING_SENSOR,
  input wire logic              ENABLE_IN,
  input wire logic              OVERRIDE_CMD,
  input wire logic              CFG_ENABLE_USED,
  input wire logic              CFG_ENABLE_ONLY,
  input wire logic [`MS_W-1:0]  CFG_CYCLE_TIMEOUT_MS,
  input wire logic              CFG_OVR_PULSED,
  input wire logic              CFG_SENSORS_ONLY,
  input wire logic              MUTING_ACTIVE,
  input wire logic              OVERRIDE_ACTIVE_OUT,
  input wire logic              OVERRIDE_REQUEST,
  input wire logic              SAFETY_SWITCHING_OUTPUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////
  // muting held while one sensor has gone
  sequence release_s;
    MUTING_ACTIVE && !(FIRST_MUTING_SENSOR && SECOND_MUTING_SENSOR);
  endsequence
  // opening fully clear
  sequence gap_free_s;
    CURTAIN_FREE && !FIRST_MUTING_SENSOR && !SECOND_MUTING_SENSOR;
  endsequence
  ////////////////////////////////////////////////////////////////////
  mute_start_a: assert property ($rose(MUTING_ACTIVE) |->
    $past(FIRST_MUTING_SENSOR) && $past(SECOND_MUTING_SENSOR))
    else $error("muting began without both sensors");
  mute_end_a: assert property (release_s |=> !MUTING_ACTIVE)
    else $error("muting outlived sensor release");
  en_cancel_a: assert property (CFG_ENABLE_USED && !CFG_ENABLE_ONLY
    && $fell(ENABLE_IN) |=> !MUTING_ACTIVE)
    else $error("enable fall did not cancel muting");
  en_only_hold_a: assert property (CFG_ENABLE_USED
    && CFG_ENABLE_ONLY
    && CFG_CYCLE_TIMEOUT_MS == 0 && $fell(ENABLE_IN) && MUTING_ACTIVE
    && FIRST_MUTING_SENSOR && SECOND_MUTING_SENSOR |=> MUTING_ACTIVE)
    else $error("enable fall cancelled muting");
  // muting seen in the same cycle as the start must already be over
  ovr_start_a: assert property ($rose(OVERRIDE_ACTIVE_OUT)
    |-> !$past(CURTAIN_FREE) && !MUTING_ACTIVE &&
    ($past(FIRST_MUTING_SENSOR) || $past(SECOND_MUTING_SENSOR) ||
    !CFG_SENSORS_ONLY))
    else $error("override began without qualifying occupancy");
  ovr_edge_a: assert property ($rose(OVERRIDE_ACTIVE_OUT) |->
    $past(OVERRIDE_CMD) && !$past(OVERRIDE_CMD, 2))
    else $error("override began without command edge");
  ovr_clear_a: assert property (OVERRIDE_ACTIVE_OUT ##0 gap_free_s
    |=> !OVERRIDE_ACTIVE_OUT)
    else $error("override outlived clear opening");
  ovr_hold_a: assert property (OVERRIDE_ACTIVE_OUT
    && !CFG_OVR_PULSED
    && !OVERRIDE_CMD |=> !OVERRIDE_ACTIVE_OUT)
    else $error("maintained override outlived command");
  ovr_output_a: assert property (OVERRIDE_ACTIVE_OUT |->
    SAFETY_SWITCHING_OUTPUT)
    else $error("override running with output off");
  ovr_request_a: assert property (OVERRIDE_REQUEST |->
    !$past(CURTAIN_FREE) && !OVERRIDE_ACTIVE_OUT)
    else $error("request raised without conditions");
endmodule
bind muting_t muting_checker u_muting_checker (
  .CLOCK(CLOCK), .RST_N(RST_N), .CURTAIN_FREE(CURTAIN_FREE),
  .FIRST_MUTING_SENSOR(FIRST_MUTING_SENSOR),
  .SECOND_MUTING_SENSOR(SECOND_MUTING_SENSOR),
  .ENABLE_IN(ENABLE_IN), .OVERRIDE_CMD(OVERRIDE_CMD),
  .CFG_ENABLE_USED(CFG_ENABLE_USED), .CFG_ENABLE_ONLY(CFG_ENABLE_ONLY),
  .CFG_CYCLE_TIMEOUT_MS(CFG_CYCLE_TIMEOUT_MS),
  .CFG_OVR_PULSED(CFG_OVR_PULSED), .CFG_SENSORS_ONLY(CFG_SENSORS_ONLY),
  .MUTING_ACTIVE(MUTING_ACTIVE), .OVERRIDE_ACTIVE_OUT(OVERRIDE_ACTIVE_OUT),
  .OVERRIDE_REQUEST(OVERRIDE_REQUEST),
  .SAFETY_SWITCHING_OUTPUT(SAFETY_SWITCHING_OUTPUT));
`default_nettype wire

// ==== muting_regs.vh ====
// Purpose: constants for the two-sensor muting block with override stage
// Assumes: 125 MHz system clock, millisecond tick for all timers
// Notes:   times in milliseconds; cycle count derived from the clock rate
`ifndef MUTING_REGS_VH
`define MUTING_REGS_VH

// clock and tick
`define CLK_FREQ_HZ        125000000
`define TICK_TIME_MS       1
`define TICK_CYCLES        ((`CLK_FREQ_HZ / 1000) * `TICK_TIME_MS)
// last divider count, TICK_CYCLES - 1 at the divider's own width
`define TICK_LAST          17'h1e847

// sensor window limits (ms)
`define SENSOR_WIN_MIN_MS  16'd2000
`define SENSOR_WIN_MAX_MS  16'd5000

// cycle and override timeout minimum (ms); zero selects unlimited
`define TIMEOUT_MIN_MS     24'd10000
`define TIMEOUT_UNLIMITED  24'h000000

// widths
`define MS_W               24
`define WIN_W              16

`endif

// ==== muting_t.v ====
// Purpose: two-sensor muting of a light curtain input plus override stage
// Assumes: all inputs synchronous to CLOCK; config ports static in use
// Notes:   timers run from a shared millisecond tick
//
// Behaviour
// - mute once both sensors cut within window
// - end muting when any sensor releases
// - start only with sensors clear, curtain free
// - cycle timeout ends muting immediately
// - without enable option, muting always permitted
// - enable/disable mode arms on rising edge only
// - enable/disable falling edge cancels muting at once
// - enable-only never cancels; enable must drop first
// - override only when not muted and occupied
// - override ends when opening fully clear
// - maintained override ends on command release, clear or timeout
// - pulsed override starts on command edge, self ends
// - sensors-occupied option restricts qualifying occupancy
// - override has its own timeout
// - override active output while override runs
// - request output when activation conditions are met
// - manual reset gates output while muted input true
// - plain reset rising edge; monitored needs full pulse
`timescale 1ns/1ps
`default_nettype none
`include "muting_regs.vh"

module muting_t (
  input  wire                CLOCK,
  input  wire                RST_N,
  input  wire                CURTAIN_FREE,        // high: curtain clear
  input  wire                FIRST_MUTING_SENSOR, // high: beam cut
  input  wire                SECOND_MUTING_SENSOR,// high: beam cut
  input  wire                ENABLE_IN,           // muting enable input
  input  wire                OVERRIDE_CMD,        // operator override
  input  wire                RESET_IN,            // operator reset button
  input  wire                CFG_ENABLE_USED,     // enable option chosen
  input  wire                CFG_ENABLE_ONLY,     // 1 enable-only, 0 en/dis
  input  wire [`WIN_W-1:0]   CFG_SENSOR_WIN_MS,   // 2000..5000
  input  wire [`MS_W-1:0]    CFG_CYCLE_TIMEOUT_MS,// 0 unlimited
  input  wire [`MS_W-1:0]    CFG_OVR_TIMEOUT_MS,  // 0 unlimited
  input  wire                CFG_OVR_PULSED,      // 1 pulsed, 0 maintained
  input  wire                CFG_SENSORS_ONLY,    // sensors-occupied option
  input  wire                CFG_MANUAL_RESET,    // reset gate chosen
  input  wire                CFG_RESET_MONITORED, // 1 needs low-high-low
  output reg                 MUTING_ACTIVE,       // muting in progress
  output reg                 MUTED_OUT,           // curtain with muting
  output reg                 OVERRIDE_ACTIVE_OUT, // override in progress
  output reg                 OVERRIDE_REQUEST,    // override may start
  output reg                 SAFETY_SWITCHING_OUTPUT // block output
);

  // muting state codes, one-hot
  localparam [3:0] ST_IDLE  = 4'b0001; // waiting for free opening
  localparam [3:0] ST_READY = 4'b0010; // preliminary condition met
  localparam [3:0] ST_FIRST = 4'b0100; // one sensor cut, window runs
  localparam [3:0] ST_MUTE  = 4'b1000; // muting active

  ////////////////////////////////////////////////////////////////////////
  // millisecond tick divider
  reg [16:0] div_reg;                  // cycle counter within a ms
  reg        tick_reg;                 // one-cycle ms enable

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      div_reg  <= 17'h00000;
      tick_reg <= 1'b0;
    end else if (div_reg == `TICK_LAST) begin
      div_reg  <= 17'h00000;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 17'h00001;
      tick_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input history for edge detection
  reg en_d_reg;                        // enable last cycle
  reg ovr_d_reg;                       // override command last cycle
  reg rst_d_reg;                       // reset button last cycle

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      en_d_reg  <= 1'b0;
      ovr_d_reg <= 1'b0;
      rst_d_reg <= 1'b0;
    end else begin
      en_d_reg  <= ENABLE_IN;
      ovr_d_reg <= OVERRIDE_CMD;
      rst_d_reg <= RESET_IN;
    end
  end

  wire en_rise  = ENABLE_IN & ~en_d_reg;
  wire en_fall  = ~ENABLE_IN & en_d_reg;
  wire ovr_rise = OVERRIDE_CMD & ~ovr_d_reg;
  wire rst_rise = RESET_IN & ~rst_d_reg;
  wire rst_fall = ~RESET_IN & rst_d_reg;

  wire s1 = FIRST_MUTING_SENSOR;
  wire s2 = SECOND_MUTING_SENSOR;

  ////////////////////////////////////////////////////////////////////////
  // enable arming: a rising edge arms one cycle, consumed at start
  reg armed_reg;                       // rising edge seen, not used yet
  reg start_mute;                      // muting starts this clock

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      armed_reg <= 1'b0;
    end else if (en_rise) begin
      armed_reg <= 1'b1;
    end else if (start_mute || (en_fall && !CFG_ENABLE_ONLY)) begin
      armed_reg <= 1'b0;               // steady level never re-arms
    end
  end

  // falling edge cancel applies only in enable/disable mode
  wire en_cancel = CFG_ENABLE_USED & !CFG_ENABLE_ONLY & en_fall;
  // without the option the enable input is ignored; a cancelling edge
  // in the same clock as the second sensor must still win
  wire permitted = (!CFG_ENABLE_USED | armed_reg) & !en_cancel;

  ////////////////////////////////////////////////////////////////////////
  // timers
  wire win_expired;                    // sensor window passed
  wire cyc_expired;                    // cycle timeout passed
  wire ovr_expired;                    // override timeout passed
  reg  [3:0] state_reg;                // muting state
  reg  [3:0] state_next;
  reg        ovr_reg;                  // override running
  reg        ovr_next;

  ms_timer #(.W(`MS_W)) win_timer (
    .clk     (CLOCK),
    .rst_n   (RST_N),
    .tick    (tick_reg),
    .run     (state_reg == ST_FIRST),
    .limit   ({8'h00, CFG_SENSOR_WIN_MS}),
    .expired (win_expired)
  );

  // cycle timeout spans from first sensor to end of muting
  ms_timer #(.W(`MS_W)) cyc_timer (
    .clk     (CLOCK),
    .rst_n   (RST_N),
    .tick    (tick_reg),
    .run     ((state_reg == ST_FIRST) || (state_reg == ST_MUTE)),
    .limit   (CFG_CYCLE_TIMEOUT_MS),
    .expired (cyc_expired)
  );

  ms_timer #(.W(`MS_W)) ovr_timer (
    .clk     (CLOCK),
    .rst_n   (RST_N),
    .tick    (tick_reg),
    .run     (ovr_reg),
    .limit   (CFG_OVR_TIMEOUT_MS),
    .expired (ovr_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // muting state machine
  always @* begin
    state_next = state_reg;
    start_mute = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // opening free and sensors clear before a cycle may begin
        if (!s1 && !s2 && CURTAIN_FREE) begin
          state_next = ST_READY;
        end
      end
      ST_READY: begin
        if (!CURTAIN_FREE) begin
          state_next = ST_IDLE;
        end else if (permitted && s1 && s2) begin
          state_next = ST_MUTE;        // both at once: in window
          start_mute = 1'b1;
        end else if (permitted && (s1 ^ s2)) begin
          state_next = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (en_cancel || cyc_expired || win_expired) begin
          state_next = ST_IDLE;
        end else if (!s1 && !s2) begin
          state_next = ST_READY;       // first sensor backed off
        end else if (s1 && s2) begin
          state_next = ST_MUTE;
          start_mute = 1'b1;
        end
      end
      ST_MUTE: begin
        if (en_cancel || cyc_expired || !s1 || !s2) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // muting output: curtain forced true while muting
  wire muted_now = (state_next == ST_MUTE);
  wire muted_in  = CURTAIN_FREE | muted_now;

  ////////////////////////////////////////////////////////////////////////
  // override stage, fed by the muted signal
  wire sens_occ = s1 | s2;
  // qualifying occupancy depends on the sensors-only option
  wire occupied = CFG_SENSORS_ONLY ? sens_occ
                                   : (sens_occ | !CURTAIN_FREE);
  wire ovr_cond = !muted_in & occupied;
  wire all_clear = !s1 & !s2 & CURTAIN_FREE;
  // a fresh command edge is needed in both modes; the maintained mode
  // additionally stops the moment the operator lets go
  wire ovr_start = ovr_cond & ovr_rise;

  always @* begin
    ovr_next = ovr_reg;
    if (ovr_reg) begin
      if (all_clear || ovr_expired) begin
        ovr_next = 1'b0;
      end else if (!CFG_OVR_PULSED && !OVERRIDE_CMD) begin
        ovr_next = 1'b0;
      end
    end else if (ovr_start) begin
      ovr_next = 1'b1;
    end
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ovr_reg <= 1'b0;
    end else begin
      ovr_reg <= ovr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operator reset: plain wants a rise, monitored wants rise then fall
  reg rst_half_reg;                    // rise seen, waiting for fall
  reg gate_reg;                        // output released by reset
  wire reset_ok = CFG_RESET_MONITORED ? (rst_fall & rst_half_reg)
                                      : rst_rise;

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_half_reg <= 1'b0;
      gate_reg     <= 1'b0;
    end else begin
      if (rst_rise) begin
        rst_half_reg <= 1'b1;
      end else if (rst_fall) begin
        rst_half_reg <= 1'b0;
      end
      // gate drops whenever the muted input goes false, so a new
      // reset is needed after every trip
      if (!muted_in) begin
        gate_reg <= 1'b0;
      end else if (reset_ok) begin
        gate_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      MUTING_ACTIVE           <= 1'b0;
      MUTED_OUT               <= 1'b0;
      OVERRIDE_ACTIVE_OUT     <= 1'b0;
      OVERRIDE_REQUEST        <= 1'b0;
      SAFETY_SWITCHING_OUTPUT <= 1'b0;
    end else begin
      MUTING_ACTIVE       <= muted_now;
      MUTED_OUT           <= muted_in;
      OVERRIDE_ACTIVE_OUT <= ovr_next;
      OVERRIDE_REQUEST    <= ovr_cond & !ovr_next;
      if (ovr_next) begin
        SAFETY_SWITCHING_OUTPUT <= 1'b1;
      end else if (CFG_MANUAL_RESET) begin
        SAFETY_SWITCHING_OUTPUT <= muted_in & (gate_reg | reset_ok);
      end else begin
        SAFETY_SWITCHING_OUTPUT <= muted_in;
      end
    end
  end

endmodule

`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for the muting block
// Assumes: run far shorter than one ms tick, so no timer expires
// Notes:   config changes only while the block is idle
`timescale 1ns/1ps
`default_nettype none
`include "muting_regs.vh"
module tb;
  logic CLOCK, RST_N, cf, s1, s2, en, cmd, btn;
  logic c_en, c_only, c_puls, c_sens, c_man, c_mon;
  logic [`WIN_W-1:0] c_win;
  logic [`MS_W-1:0] c_cyc, c_ovr;
  logic mact, mout, oact, oreq, safe;
  int n_mismatch, check_count;
  field_model u_field_model (.clk(CLOCK), .cf(cf), .s1(s1), .s2(s2),
    .en(en), .cmd(cmd), .btn(btn));
  muting_t u_muting_t (.CLOCK(CLOCK), .RST_N(RST_N), .CURTAIN_FREE(cf),
    .FIRST_MUTING_SENSOR(s1), .SECOND_MUTING_SENSOR(s2), .ENABLE_IN(en),
    .OVERRIDE_CMD(cmd), .RESET_IN(btn), .CFG_ENABLE_USED(c_en),
    .CFG_ENABLE_ONLY(c_only), .CFG_SENSOR_WIN_MS(c_win),
    .CFG_CYCLE_TIMEOUT_MS(c_cyc), .CFG_OVR_TIMEOUT_MS(c_ovr),
    .CFG_OVR_PULSED(c_puls), .CFG_SENSORS_ONLY(c_sens),
    .CFG_MANUAL_RESET(c_man), .CFG_RESET_MONITORED(c_mon),
    .MUTING_ACTIVE(mact), .MUTED_OUT(mout), .OVERRIDE_ACTIVE_OUT(oact),
    .OVERRIDE_REQUEST(oreq), .SAFETY_SWITCHING_OUTPUT(safe));
  ////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  task wt(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  task chk(input string nm, input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %0s expected %b seen %b", nm, exp, seen);
    end
  endtask
  // free opening, then both beams, then curtain blocked by the load
  task cycle_on;
    u_field_model.scene(1'b1, 1'b0, 1'b0);
    wt(2);
    u_field_model.scene(1'b1, 1'b1, 1'b1);
    wt(2);
    u_field_model.scene(1'b0, 1'b1, 1'b1);
    wt(2);
  endtask
  task release_all;
    u_field_model.scene(1'b1, 1'b0, 1'b0);
    wt(3);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // cut a hang short well beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge CLOCK);
    n_mismatch++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    RST_N = 1'b0;
    {c_en, c_only, c_puls, c_sens, c_man, c_mon} = 6'h08;
    c_win = `SENSOR_WIN_MIN_MS;
    c_cyc = `TIMEOUT_MIN_MS;
    c_ovr = `TIMEOUT_MIN_MS;
    wt(5);
    chk("idle outputs", |{mact, mout, oact, oreq, safe}, 1'b0);
    RST_N = 1'b1;
    wt(2);
    cycle_on();
    chk("muted out", mout, 1'b1);
    u_field_model.scene(1'b0, 1'b0, 1'b1);
    wt(3);
    chk("muting", mact, 1'b0);
    chk("request", oreq, 1'b1);
    u_field_model.scene(1'b0, 1'b1, 1'b1);
    wt(3);
    chk("muting", mact, 1'b0);
    u_field_model.put_cmd(1'b1);
    wt(2);
    chk("override", oact, 1'b1);
    chk("safety", safe, 1'b1);
    u_field_model.put_cmd(1'b0);
    wt(2);
    chk("override", oact, 1'b1);
    // command held through the clear: no restart on re-occupancy
    u_field_model.put_cmd(1'b1);
    release_all();
    chk("override", oact, 1'b0);
    u_field_model.scene(1'b0, 1'b1, 1'b1);
    wt(3);
    chk("override", oact, 1'b0);
    chk("request", oreq, 1'b1);
    u_field_model.put_cmd(1'b0);
    release_all();
    $display("test mute_pulsed done");
    c_puls = 1'b0;
    c_sens = 1'b1;
    c_ovr = `TIMEOUT_UNLIMITED;
    u_field_model.scene(1'b0, 1'b0, 1'b0);
    wt(3);
    chk("request", oreq, 1'b0);
    u_field_model.put_cmd(1'b1);
    wt(2);
    chk("override", oact, 1'b0);
    u_field_model.put_cmd(1'b0);
    u_field_model.scene(1'b0, 1'b1, 1'b0);
    wt(3);
    u_field_model.put_cmd(1'b1);
    wt(2);
    chk("override", oact, 1'b1);
    release_all();
    chk("override", oact, 1'b0);
    u_field_model.put_cmd(1'b0);
    u_field_model.scene(1'b0, 1'b1, 1'b0);
    wt(3);
    u_field_model.put_cmd(1'b1);
    wt(2);
    chk("override", oact, 1'b1);
    u_field_model.put_cmd(1'b0);
    wt(2);
    chk("override", oact, 1'b0);
    release_all();
    $display("test maintained done");
    c_en = 1'b1;
    c_cyc = `TIMEOUT_UNLIMITED;
    c_win = `SENSOR_WIN_MAX_MS;
    cycle_on();
    chk("muting", mact, 1'b0);
    release_all();
    u_field_model.put_en(1'b1);
    wt(2);
    cycle_on();
    chk("muting", mact, 1'b1);
    release_all();
    cycle_on();
    chk("muting", mact, 1'b0);
    release_all();
    u_field_model.put_en(1'b0);
    u_field_model.put_en(1'b1);
    cycle_on();
    u_field_model.put_en(1'b0);
    wt(3);
    chk("muting", mact, 1'b0);
    release_all();
    // falling edge in the very clock that both beams are cut
    u_field_model.put_en(1'b1);
    fork
      u_field_model.put_en(1'b0);
      u_field_model.scene(1'b1, 1'b1, 1'b1);
    join
    wt(2);
    chk("muting", mact, 1'b0);
    release_all();
    c_only = 1'b1;
    u_field_model.put_en(1'b1);
    cycle_on();
    u_field_model.put_en(1'b0);
    wt(3);
    chk("muting", mact, 1'b1);
    u_field_model.put_cmd(1'b1);
    wt(2);
    chk("override", oact, 1'b0);
    u_field_model.put_cmd(1'b0);
    release_all();
    $display("test enable done");
    c_en = 1'b0;
    c_man = 1'b1;
    wt(3);
    chk("safety", safe, 1'b0);
    u_field_model.put_btn(1'b1);
    wt(3);
    chk("safety", safe, 1'b1);
    u_field_model.put_btn(1'b0);
    u_field_model.scene(1'b0, 1'b0, 1'b0);
    wt(3);
    chk("safety", safe, 1'b0);
    release_all();
    c_mon = 1'b1;
    u_field_model.put_btn(1'b1);
    wt(3);
    chk("safety", safe, 1'b0);
    u_field_model.put_btn(1'b0);
    wt(3);
    chk("safety", safe, 1'b1);
    $display("test manual_reset done");
    // power-on reset in mid-run clears the reset gate as well
    RST_N = 1'b0;
    wt(2);
    chk("reset outputs", |{mact, mout, oact, oreq, safe}, 1'b0);
    RST_N = 1'b1;
    wt(3);
    chk("muted out", mout, 1'b1);
    chk("safety", safe, 1'b0);
    $display("test reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
